// file: hdl/cpu_cfg_pkg.sv
// How it works
// - An interrupt request is taken only when its level is numerically below the mask.
// - The level mask is five bits wide, level 0 is the highest priority and 31 the lowest.
// - A set trace flag raises a step trace trap after each finished instruction.
// - After reset registers 0 to 14 hold no defined value and register 15 holds zero.
// - Register 13 is the accumulator, 14 the frame pointer and 15 the stack pointer.
// - Strap code 000 selects an external reset vector with an 8-bit external data bus.
// - Strap code 001 selects an external reset vector with a 16-bit external data bus.
// - Strap code 011 asks for internal vector fetch, which this part cannot serve.
// - The bus-mode bits decode 00 single-chip, 01 internal ROM, 10 external ROM, 11 inhibited.
package cpu_cfg_pkg;

    localparam int          LEVEL_W          = 5;
    localparam logic [4:0]  LEVEL_HIGHEST    = 5'h00;
    localparam logic [4:0]  LEVEL_LOWEST     = 5'h1F;
    localparam logic [4:0]  LEVEL_MASK_RESET = 5'h1F;

    localparam int          TRACE_BIT        = 0;

    localparam logic [1:0]  BUS_SINGLE_CHIP  = 2'h0;
    localparam logic [1:0]  BUS_INT_ROM      = 2'h1;
    localparam logic [1:0]  BUS_EXT_ROM      = 2'h2;
    localparam logic [1:0]  BUS_INHIBITED    = 2'h3;
    localparam logic [1:0]  BUS_MODE_RESET   = 2'h2;

    localparam logic [2:0]  STRAP_EXT_8      = 3'h0;
    localparam logic [2:0]  STRAP_EXT_16     = 3'h1;
    localparam logic [2:0]  STRAP_BLOCKED    = 3'h2;
    localparam logic [2:0]  STRAP_INT_VEC    = 3'h3;

    localparam logic [7:0]  OFS_LEVEL_MASK   = 8'h00;
    localparam logic [7:0]  OFS_CONDITION    = 8'h04;
    localparam logic [7:0]  OFS_BUS_MODE     = 8'h08;
    localparam logic [7:0]  OFS_STATUS       = 8'h0C;
    localparam logic [7:0]  OFS_GPR_BASE     = 8'h40;

    localparam int          GPR_COUNT        = 16;
    localparam logic [3:0]  IDX_ACCUMULATOR  = 4'hD;
    localparam logic [3:0]  IDX_FRAME        = 4'hE;
    localparam logic [3:0]  IDX_STACK        = 4'hF;
    localparam logic [31:0] STACK_RESET      = 32'h0000_0000;

    localparam int          ST_STRAP_LSB     = 0;
    localparam int          ST_INHIBITED     = 3;
    localparam int          ST_EXT_VECTOR    = 4;
    localparam int          ST_BUS_16        = 5;
    localparam int          ST_INT_VECTOR    = 6;
    localparam int          ST_CAPTURED      = 7;
    localparam int          ST_BUS_MODE_LSB  = 8;
    localparam int          ST_BUS_ILLEGAL   = 10;

endpackage

// file: hdl/mode_if.sv
`timescale 1ns/10ps
interface mode_if;
    logic [2:0] strap_code;
    logic       vector_external;
    logic       bus_16;
    logic       internal_vector;
    logic       inhibited;
    logic       captured;

    modport producer (
        output strap_code,
        output vector_external,
        output bus_16,
        output internal_vector,
        output inhibited,
        output captured
    );

    modport consumer (
        input  strap_code,
        input  vector_external,
        input  bus_16,
        input  internal_vector,
        input  inhibited,
        input  captured
    );
endinterface

// file: hdl/strap_decoder.sv
`timescale 1ns/10ps
module strap_decoder (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_ce,
    input  wire logic [2:0] i_mode_strap,
    mode_if.producer        mode
);
    typedef enum logic {CAP_ARMED, CAP_HELD} cap_state_t;

    // Synchroniser has no reset so it keeps sampling the pins while reset is held
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;
    cap_state_t state;
    cap_state_t next_state;
    logic [2:0] next_code;
    logic       next_ext;
    logic       next_b16;
    logic       next_int;
    logic       next_inh;
    logic       next_cap;

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            strap_meta <= i_mode_strap;
            strap_sync <= strap_meta;
        end
    end

    always_comb begin
        next_state = state;
        next_code  = mode.strap_code;
        next_ext   = mode.vector_external;
        next_b16   = mode.bus_16;
        next_int   = mode.internal_vector;
        next_inh   = mode.inhibited;
        next_cap   = mode.captured;
        case (state)
            CAP_ARMED: begin
                // First edge after release takes the level seen during reset
                next_state = CAP_HELD;
                next_cap   = 1'b1;
                next_code  = strap_sync;
                next_ext   = 1'b0;
                next_b16   = 1'b0;
                next_int   = 1'b0;
                next_inh   = 1'b0;
                case (strap_sync)
                    cpu_cfg_pkg::STRAP_EXT_8: begin
                        next_ext = 1'b1;
                    end
                    cpu_cfg_pkg::STRAP_EXT_16: begin
                        next_ext = 1'b1;
                        next_b16 = 1'b1;
                    end
                    cpu_cfg_pkg::STRAP_INT_VEC: begin
                        // No single-chip support, so this code is flagged as unusable
                        next_int = 1'b1;
                        next_inh = 1'b1;
                    end
                    default: begin
                        next_inh = 1'b1;
                    end
                endcase
            end
            CAP_HELD: begin
                next_state = CAP_HELD;
            end
            default: begin
                next_state = CAP_ARMED;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state                <= CAP_ARMED;
            mode.strap_code      <= 3'h0;
            mode.vector_external <= 1'b1;
            mode.bus_16          <= 1'b0;
            mode.internal_vector <= 1'b0;
            mode.inhibited       <= 1'b0;
            mode.captured        <= 1'b0;
        end else if (i_ce) begin
            state                <= next_state;
            mode.strap_code      <= next_code;
            mode.vector_external <= next_ext;
            mode.bus_16          <= next_b16;
            mode.internal_vector <= next_int;
            mode.inhibited       <= next_inh;
            mode.captured        <= next_cap;
        end
    end

    chk_strap_frozen_held: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        mode.captured && $past(mode.captured) |-> $stable(mode.strap_code) && $stable(mode.bus_16))
        else $error("strap decode changed after capture");
    chk_strap_ext_eight: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        mode.captured && mode.strap_code == cpu_cfg_pkg::STRAP_EXT_8
        |-> mode.vector_external && !mode.bus_16 && !mode.inhibited)
        else $error("strap 000 not decoded as external 8-bit");
    chk_strap_ext_sixteen: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        mode.captured && mode.strap_code == cpu_cfg_pkg::STRAP_EXT_16
        |-> mode.vector_external && mode.bus_16 && !mode.inhibited)
        else $error("strap 001 not decoded as external 16-bit");
    chk_strap_unusable_codes: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        mode.captured |-> mode.inhibited == (mode.strap_code[2] ||
            mode.strap_code == cpu_cfg_pkg::STRAP_BLOCKED ||
            mode.strap_code == cpu_cfg_pkg::STRAP_INT_VEC))
        else $error("unusable strap code not flagged");
endmodule

// file: hdl/cpu_mode_and_level_mask.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module cpu_mode_and_level_mask #(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_ce,
    input  wire logic [2:0]        i_mode_strap,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    input  wire logic              i_irq_req,
    input  wire logic [4:0]        i_irq_level,
    input  wire logic              i_insn_done,
    output logic                   o_irq_accept,
    output logic                   o_trace_trap,
    output logic      [4:0]        o_level_mask,
    output logic                   o_trace_enable,
    output logic      [31:0]       o_virtual_accumulator,
    output logic      [31:0]       o_frame_pointer,
    output logic      [31:0]       o_stack_pointer,
    output logic                   o_ext_vector,
    output logic                   o_ext_bus_16,
    output logic                   o_internal_vector,
    output logic                   o_strap_inhibited,
    output logic                   o_mode_captured,
    output logic      [1:0]        o_bus_mode_code,
    output logic                   o_bus_ext_rom,
    output logic                   o_bus_mode_illegal
);
    if (ADDR_W < 7 || ADDR_W > 16) begin : g_addr_check
        $error("ADDR_W must lie between 7 and 16");
    end

    localparam logic [ADDR_W-1:0] A_LEVEL  = ADDR_W'(cpu_cfg_pkg::OFS_LEVEL_MASK);
    localparam logic [ADDR_W-1:0] A_COND   = ADDR_W'(cpu_cfg_pkg::OFS_CONDITION);
    localparam logic [ADDR_W-1:0] A_BUS    = ADDR_W'(cpu_cfg_pkg::OFS_BUS_MODE);
    localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(cpu_cfg_pkg::OFS_STATUS);
    localparam logic [ADDR_W-1:0] A_GPR    = ADDR_W'(cpu_cfg_pkg::OFS_GPR_BASE);

    mode_if mode ();

    strap_decoder u_strap (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_ce         (i_ce),
        .i_mode_strap (i_mode_strap),
        .mode         (mode.producer)
    );

    // Smaller level number wins, so a request beats the mask only when strictly below it
    function automatic logic level_beats(input logic [4:0] level, input logic [4:0] mask);
        return level < mask;
    endfunction

    // Register file window: sixteen aligned words starting at the base offset
    function automatic logic gpr_hit(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] rel;
        rel = addr - A_GPR;
        return (addr >= A_GPR) && (rel < ADDR_W'(cpu_cfg_pkg::GPR_COUNT * 4)) &&
               (addr[1:0] == 2'h0);
    endfunction

    function automatic logic [3:0] gpr_index(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] rel;
        rel = addr - A_GPR;
        return rel[5:2];
    endfunction

    // Control registers
    logic [4:0]  level_mask;
    logic        trace_en;
    logic [1:0]  bus_mode;
    logic        bus_ext_rom;
    logic        bus_illegal;
    logic [31:0] stack_ptr;
    logic [4:0]  next_level_mask;
    logic        next_trace_en;
    logic [1:0]  next_bus_mode;
    logic        next_bus_ext_rom;
    logic        next_bus_illegal;
    logic [31:0] next_stack_ptr;

    always_comb begin
        next_level_mask = level_mask;
        next_trace_en   = trace_en;
        next_bus_mode   = bus_mode;
        next_stack_ptr  = stack_ptr;
        if (i_wr) begin
            if (i_addr == A_LEVEL) begin
                next_level_mask = i_wdata[4:0];
            end
            if (i_addr == A_COND) begin
                next_trace_en = i_wdata[cpu_cfg_pkg::TRACE_BIT];
            end
            if (i_addr == A_BUS) begin
                // Any code is stored so software can see what it wrote
                next_bus_mode = i_wdata[1:0];
            end
            if (gpr_hit(i_addr) && gpr_index(i_addr) == cpu_cfg_pkg::IDX_STACK) begin
                next_stack_ptr = i_wdata;
            end
        end
        next_bus_ext_rom = 1'b0;
        next_bus_illegal = 1'b1;
        case (next_bus_mode)
            cpu_cfg_pkg::BUS_SINGLE_CHIP: begin
                next_bus_illegal = 1'b1;
            end
            cpu_cfg_pkg::BUS_INT_ROM: begin
                next_bus_illegal = 1'b1;
            end
            cpu_cfg_pkg::BUS_EXT_ROM: begin
                // Only usable setting: there is no on-chip ROM
                next_bus_ext_rom = 1'b1;
                next_bus_illegal = 1'b0;
            end
            cpu_cfg_pkg::BUS_INHIBITED: begin
                next_bus_illegal = 1'b1;
            end
            default: begin
                next_bus_illegal = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            level_mask  <= cpu_cfg_pkg::LEVEL_MASK_RESET;
            trace_en    <= 1'b0;
            bus_mode    <= cpu_cfg_pkg::BUS_MODE_RESET;
            bus_ext_rom <= 1'b1;
            bus_illegal <= 1'b0;
            stack_ptr   <= cpu_cfg_pkg::STACK_RESET;
        end else if (i_ce) begin
            level_mask  <= next_level_mask;
            trace_en    <= next_trace_en;
            bus_mode    <= next_bus_mode;
            bus_ext_rom <= next_bus_ext_rom;
            bus_illegal <= next_bus_illegal;
            stack_ptr   <= next_stack_ptr;
        end
    end

    // Registers 0 to 14: no reset, their content is undefined after reset
    logic [31:0] gpr [0:cpu_cfg_pkg::GPR_COUNT-2];
    logic        gpr_we;
    logic [3:0]  gpr_wsel;

    always_comb begin
        gpr_wsel = gpr_index(i_addr);
        gpr_we   = i_wr && gpr_hit(i_addr) && (gpr_wsel != cpu_cfg_pkg::IDX_STACK);
    end

    always_ff @(posedge i_clk) begin
        if (i_ce && gpr_we) begin
            gpr[gpr_wsel] <= i_wdata;
        end
    end

    // Interrupt acceptance, step trace and read port
    logic        irq_accept;
    logic        trace_trap;
    logic [31:0] rdata;
    logic        next_irq_accept;
    logic        next_trace_trap;
    logic [31:0] next_rdata;
    logic [3:0]  rsel;

    always_comb begin
        // A losing request is simply not taken; the source keeps it pending
        next_irq_accept = i_irq_req && level_beats(i_irq_level, level_mask);
        next_trace_trap = trace_en && i_insn_done;
        rsel            = gpr_index(i_addr);
        next_rdata      = 32'h0000_0000;
        if (i_rd) begin
            if (i_addr == A_LEVEL) begin
                next_rdata[4:0] = level_mask;
            end else if (i_addr == A_COND) begin
                next_rdata[cpu_cfg_pkg::TRACE_BIT] = trace_en;
            end else if (i_addr == A_BUS) begin
                next_rdata[1:0] = bus_mode;
            end else if (i_addr == A_STATUS) begin
                next_rdata[cpu_cfg_pkg::ST_STRAP_LSB +: 3] = mode.strap_code;
                next_rdata[cpu_cfg_pkg::ST_INHIBITED]      = mode.inhibited;
                next_rdata[cpu_cfg_pkg::ST_EXT_VECTOR]     = mode.vector_external;
                next_rdata[cpu_cfg_pkg::ST_BUS_16]         = mode.bus_16;
                next_rdata[cpu_cfg_pkg::ST_INT_VECTOR]     = mode.internal_vector;
                next_rdata[cpu_cfg_pkg::ST_CAPTURED]       = mode.captured;
                next_rdata[cpu_cfg_pkg::ST_BUS_MODE_LSB +: 2] = bus_mode;
                next_rdata[cpu_cfg_pkg::ST_BUS_ILLEGAL]    = bus_illegal;
            end else if (gpr_hit(i_addr)) begin
                if (rsel == cpu_cfg_pkg::IDX_STACK) begin
                    next_rdata = stack_ptr;
                end else begin
                    next_rdata = gpr[rsel];
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_accept <= 1'b0;
            trace_trap <= 1'b0;
            rdata      <= 32'h0000_0000;
        end else if (i_ce) begin
            irq_accept <= next_irq_accept;
            trace_trap <= next_trace_trap;
            rdata      <= next_rdata;
        end
    end

    assign o_rdata               = rdata;
    assign o_irq_accept          = irq_accept;
    assign o_trace_trap          = trace_trap;
    assign o_level_mask          = level_mask;
    assign o_trace_enable        = trace_en;
    assign o_virtual_accumulator = gpr[cpu_cfg_pkg::IDX_ACCUMULATOR];
    assign o_frame_pointer       = gpr[cpu_cfg_pkg::IDX_FRAME];
    assign o_stack_pointer       = stack_ptr;
    assign o_ext_vector          = mode.vector_external;
    assign o_ext_bus_16          = mode.bus_16;
    assign o_internal_vector     = mode.internal_vector;
    assign o_strap_inhibited     = mode.inhibited;
    assign o_mode_captured       = mode.captured;
    assign o_bus_mode_code       = bus_mode;
    assign o_bus_ext_rom         = bus_ext_rom;
    assign o_bus_mode_illegal    = bus_illegal;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    chk_irq_taken_above: assert property (
        i_ce && i_irq_req && (i_irq_level < level_mask) |=> o_irq_accept)
        else $error("winning interrupt request not accepted");
    chk_irq_held_off: assert property (
        i_ce && (i_irq_level >= level_mask) |=> !o_irq_accept)
        else $error("interrupt accepted at or below mask level");
    chk_level_lowest_never: assert property (
        i_ce && i_irq_req && i_irq_level == cpu_cfg_pkg::LEVEL_LOWEST |=> !o_irq_accept)
        else $error("lowest level request was accepted");
    chk_level_highest_wins: assert property (
        i_ce && i_irq_req && i_irq_level == cpu_cfg_pkg::LEVEL_HIGHEST &&
        level_mask != cpu_cfg_pkg::LEVEL_HIGHEST |=> o_irq_accept)
        else $error("level 0 request lost against a nonzero mask");
    chk_trace_trap_follows: assert property (
        i_ce && i_insn_done |=> o_trace_trap == $past(trace_en))
        else $error("trace trap does not follow trace flag");
    chk_stack_after_reset: assert property (
        $fell(i_sys_rst) |-> o_stack_pointer == cpu_cfg_pkg::STACK_RESET)
        else $error("stack pointer not zero after reset");
    chk_stack_write_reach: assert property (
        i_ce && i_wr && gpr_hit(i_addr) && gpr_index(i_addr) == cpu_cfg_pkg::IDX_STACK
        |=> (o_stack_pointer == $past(i_wdata)) and
            ((!i_wr || !i_ce) |=> $stable(o_stack_pointer)))
        else $error("stack pointer write not taken or not kept");
    chk_bus_mode_decode: assert property (
        o_bus_ext_rom == (o_bus_mode_code == cpu_cfg_pkg::BUS_EXT_ROM) &&
        o_bus_mode_illegal == !o_bus_ext_rom)
        else $error("bus mode flags disagree with stored code");
    chk_read_one_cycle: assert property (
        i_ce && i_rd && i_addr == A_LEVEL |=> o_rdata == {27'h0, $past(level_mask)})
        else $error("level mask read data wrong or late");

    chk_mask_write_taken: assert property (
        i_ce && i_wr && i_addr == A_LEVEL |=> o_level_mask == $past(i_wdata[4:0]))
        else $error("level mask write not taken");
    chk_trace_flag_write: assert property (
        i_ce && i_wr && i_addr == A_COND
        |=> o_trace_enable == $past(i_wdata[cpu_cfg_pkg::TRACE_BIT]))
        else $error("trace flag write not taken");
    chk_bus_code_write: assert property (
        i_ce && i_wr && i_addr == A_BUS |=> o_bus_mode_code == $past(i_wdata[1:0]))
        else $error("bus mode write not taken");
    chk_accum_write_reach: assert property (
        i_ce && i_wr && gpr_hit(i_addr) && gpr_index(i_addr) == cpu_cfg_pkg::IDX_ACCUMULATOR
        |=> o_virtual_accumulator == $past(i_wdata))
        else $error("accumulator write not taken");
    chk_frame_write_reach: assert property (
        i_ce && i_wr && gpr_hit(i_addr) && gpr_index(i_addr) == cpu_cfg_pkg::IDX_FRAME
        |=> o_frame_pointer == $past(i_wdata))
        else $error("frame pointer write not taken");
    chk_frozen_while_idle: assert property (
        !i_ce |=> $stable(o_level_mask) && $stable(o_irq_accept) && $stable(o_rdata))
        else $error("state moved while clock enable low");
    chk_rdata_idle_zero: assert property (
        i_ce && !i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data not zero without a read");
    chk_mode_stays_fixed: assert property (
        o_mode_captured |=> o_mode_captured && $stable(o_ext_vector) && $stable(o_ext_bus_16))
        else $error("strap mode changed before reset");
    chk_irq_needs_request: assert property (
        i_ce && !i_irq_req |=> !o_irq_accept)
        else $error("interrupt accepted without a request");

    cov_irq_accepted:  cover property (i_irq_req ##1 o_irq_accept);
    cov_trace_trap:    cover property (o_trace_enable && o_trace_trap);
    cov_stack_written: cover property ($changed(o_stack_pointer));
    cov_bus_illegal:   cover property ($rose(o_bus_mode_illegal));
    cov_strap_blocked: cover property ($rose(o_mode_captured) && o_strap_inhibited);
endmodule

// file: dv/strap_irq_src.sv
`timescale 1ns/10ps
module strap_irq_src (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_strap_sel,
    input  wire logic       i_req,
    input  wire logic [4:0] i_level,
    output logic      [2:0] o_mode_strap,
    output logic            o_irq_req,
    output logic      [4:0] o_irq_level
);
    logic [4:0] last_level = 5'h0A;

    // Only strap codes 000, 001 and 011 are ever offered to the block
    always_comb begin
        case (i_strap_sel)
            2'h0:    o_mode_strap = 3'h0;
            2'h1:    o_mode_strap = 3'h1;
            default: o_mode_strap = 3'h3;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_req) begin
            last_level <= i_level;
        end
    end

    // An idle source shows the inverse level, so a stale level can never pass for live
    assign o_irq_req   = i_req;
    assign o_irq_level = i_req ? i_level : ~last_level;
endmodule

// file: dv/cpu_mode_and_level_mask_tb.sv
`timescale 1ns/10ps
module cpu_mode_and_level_mask_tb;
    logic        clk, rst, ce, wr, rd, req, insn_done, irq_req, irq_accept, trace_trap, trace_en;
    logic        ext_vec, bus16, int_vec, inhib, captured, ext_rom, bm_ill;
    logic [1:0]  strap_sel, bm_code;
    logic [2:0]  mode_strap, code;
    logic [4:0]  level, irq_level, level_mask, m, l;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, acc, fp, sp, rd_v, v;
    logic [4:0]  cm [5] = '{5'h00, 5'h01, 5'h1F, 5'h08, 5'h1F};
    logic [4:0]  cl [5] = '{5'h00, 5'h00, 5'h1E, 5'h08, 5'h1F};
    int          fail_count, n_checks, seed, i;

    strap_irq_src strap_irq_src_inst (.i_clk(clk), .i_strap_sel(strap_sel), .i_req(req),
        .i_level(level), .o_mode_strap(mode_strap), .o_irq_req(irq_req), .o_irq_level(irq_level));

    cpu_mode_and_level_mask #(.ADDR_W(8)) cpu_mode_and_level_mask_inst (
        .i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_mode_strap(mode_strap), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_irq_req(irq_req),
        .i_irq_level(irq_level), .i_insn_done(insn_done), .o_irq_accept(irq_accept),
        .o_trace_trap(trace_trap), .o_level_mask(level_mask), .o_trace_enable(trace_en),
        .o_virtual_accumulator(acc), .o_frame_pointer(fp), .o_stack_pointer(sp),
        .o_ext_vector(ext_vec), .o_ext_bus_16(bus16), .o_internal_vector(int_vec),
        .o_strap_inhibited(inhib), .o_mode_captured(captured), .o_bus_mode_code(bm_code),
        .o_bus_ext_rom(ext_rom), .o_bus_mode_illegal(bm_ill));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample exactly there
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic do_reset(input logic [1:0] s);
        @(posedge clk);
        rst <= 1'b1;
        strap_sel <= s;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Status word right after reset: bus mode still at its reset code
    function automatic logic [31:0] status_exp(input logic [2:0] c);
        logic inh;
        inh = (c != 3'h0) && (c != 3'h1);
        return {21'h0, 1'b0, 2'h2, 1'b1, c == 3'h3, c == 3'h1, !inh, inh, c};
    endfunction

    initial begin
        rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; req = 1'b0; insn_done = 1'b0;
        strap_sel = 2'h0; level = 5'h00; addr = 8'h00; wdata = 32'h0;
        fail_count = 0; n_checks = 0; seed = 66055;
        for (i = 0; i < 3; i++) begin
            do_reset(i[1:0]);
            code = (i == 2) ? 3'h3 : i[2:0];
            check("reset_mask", level_mask, cpu_cfg_pkg::LEVEL_MASK_RESET);
            check("reset_stack", sp, cpu_cfg_pkg::STACK_RESET);
            check("ext_vector", ext_vec, code < 3'h2);
            check("bus_16", bus16, code == 3'h1);
            check("int_vector", int_vec, code == 3'h3);
            bus_rd(cpu_cfg_pkg::OFS_STATUS, rd_v);
            check("status", rd_v, status_exp(code));
            @(posedge clk);
            strap_sel <= 2'((i + 1) % 3);
            repeat (4) @(posedge clk);
            #1;
            check("mode_held", {captured, ext_vec, int_vec, inhib},
                  {1'b1, code < 3'h2, code == 3'h3, code > 3'h1});
        end
        bus_rd(cpu_cfg_pkg::OFS_GPR_BASE + 8'h3C, rd_v);
        check("stack_read", rd_v, 32'h0000_0000);
        bus_wr(8'h30, 32'hFFFF_FFFF);
        bus_rd(8'h30, rd_v);
        check("unmapped", rd_v, 32'h0);
        @(posedge clk);
        ce <= 1'b0;
        bus_wr(cpu_cfg_pkg::OFS_LEVEL_MASK, 32'h3);
        @(posedge clk);
        ce <= 1'b1;
        #1;
        check("mask_frozen", level_mask, 5'h1F);
        for (i = 13; i < 16; i++) begin
            v = $random(seed);
            bus_wr(cpu_cfg_pkg::OFS_GPR_BASE + 8'(4 * i), v);
            check("gpr_out", (i == 13) ? acc : (i == 14) ? fp : sp, v);
        end
        for (i = 0; i < 40; i++) begin
            m = (i < 5) ? cm[i] : 5'($random(seed));
            l = (i < 5) ? cl[i] : 5'($random(seed));
            bus_wr(cpu_cfg_pkg::OFS_LEVEL_MASK, {27'h0, m});
            check("mask", level_mask, m);
            bus_rd(cpu_cfg_pkg::OFS_LEVEL_MASK, rd_v);
            check("mask_read", rd_v, {27'h0, m});
            @(posedge clk);
            req <= 1'b1;
            level <= l;
            @(posedge clk);
            req <= 1'b0;
            #1;
            check("accept", irq_accept, l < m);
        end
        for (i = 0; i < 2; i++) begin
            bus_wr(cpu_cfg_pkg::OFS_CONDITION, 32'(i));
            check("trace_en", trace_en, 32'(i));
            bus_rd(cpu_cfg_pkg::OFS_CONDITION, rd_v);
            check("trace_read", rd_v, 32'(i));
            @(posedge clk);
            insn_done <= 1'b1;
            @(posedge clk);
            insn_done <= 1'b0;
            #1;
            check("trace_trap", trace_trap, 32'(i));
            @(posedge clk);
            #1;
            check("trap_gone", trace_trap, 1'b0);
        end
        for (i = 0; i < 4; i++) begin
            bus_wr(cpu_cfg_pkg::OFS_BUS_MODE, 32'(i));
            check("bus_mode", {bm_code, ext_rom, bm_ill}, {i[1:0], i == 2, i != 2});
            bus_rd(cpu_cfg_pkg::OFS_BUS_MODE, rd_v);
            check("bus_read", rd_v, 32'(i));
        end
        bus_wr(cpu_cfg_pkg::OFS_BUS_MODE, {30'h0, cpu_cfg_pkg::BUS_EXT_ROM});
        tally_and_finish();
    end

    initial begin
        #(20 * 20000);
        fail_count++;
        tally_and_finish();
    end
endmodule
